// >>> logic/rtcis_defines.vh
`ifndef RTCIS_DEFINES_VH
`define RTCIS_DEFINES_VH
// ---------------------------------------------------------------
// i2c address and register map
// ---------------------------------------------------------------
`define RTCIS_SLAVE_ADDR    7'h32
`define RTCIS_ADDR_TOP      4'hf
`define RTCIS_REG_EXT       4'hd
`define RTCIS_REG_FLAG      4'he
`define RTCIS_REG_CTRL      4'hf
// extension register test bit
`define RTCIS_EXT_TEST      7
// flag register bits
`define RTCIS_FLAG_UPDATE   5
`define RTCIS_FLAG_TIMER    4
`define RTCIS_FLAG_ALARM    3
`define RTCIS_FLAG_VLOW     1
`define RTCIS_FLAG_VDROP    0
// write-zero-only mask in the flag register
`define RTCIS_FLAG_W0_MASK  8'h3b
// control register fields
`define RTCIS_CTRL_CSEL_HI  7
`define RTCIS_CTRL_CSEL_LO  6
`define RTCIS_CTRL_UIE      5
`define RTCIS_CTRL_TIE      4
`define RTCIS_CTRL_AIE      3
`define RTCIS_CTRL_RESET    0
// power-up values
`define RTCIS_RST_FLAG      8'h02
`define RTCIS_RST_EXT       8'h00
`define RTCIS_RST_OTHER     8'h00
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RTCIS_CLK_HZ        40000000
`define RTCIS_TIMEOUT_MS    950
`define RTCIS_TIMEOUT_CYC   ((`RTCIS_CLK_HZ / 1000) * `RTCIS_TIMEOUT_MS)
`endif

// >>> logic/rtcis_fifo.v
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// small fifo on the received byte path
// ---------------------------------------------------------------
module rtcis_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  input  wire             flush,
  // write side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // read side
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  localparam [AW:0] DEPTH_W = DEPTH;

  // output register is extra storage beyond the DEPTH slots
  assign in_ready = (count < DEPTH_W);
  assign push     = in_valid && in_ready;
  assign pop      = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  // storage and pointers
  always @(posedge clk_sys) begin
    if (rst || flush) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_ptr];
        rd_ptr   <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // rtcis_fifo
`default_nettype wire

// >>> logic/rtcis_slave.v
`timescale 1ns/10ps
`default_nettype none
`include "rtcis_defines.vh"
// What this block does
// - power-up clears test bit, sets voltage-low flag
// - other registers cleared to zero at power-up
// - event flags accept only written zero
// - start: sda falls while scl high
// - stop: sda rises while scl high
// - stop accepted at any receive bit
// - 0.95 s without stop drops to standby
// - after timeout writes ignored, reads ones
// - bytes of eight bits, unlimited count
// - pointer increments per byte, wraps f to 0
// - sda changes only while scl low, except the release when a timeout fires
// - receiver acks low on ninth clock
// - no ack from master ends read
// - respond only to own address
// - address 0110010 plus read/write bit
module rtcis_slave #(
  parameter TIMEOUT_CYC = `RTCIS_TIMEOUT_CYC
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // i2c pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // register view
  output reg  [7:0] ctrl_reg,
  output reg  [7:0] flag_reg,
  output reg        bus_active,
  output reg        timed_out
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_ACK   = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_RACK  = 3'd5;
  localparam ST_DEAD  = 3'd6;

  reg  [2:0]  state;
  reg  [1:0]  scl_sync;
  reg  [1:0]  sda_sync;
  reg         scl_q;
  reg         sda_q;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shift;
  reg         is_read;
  reg         first_byte;
  reg  [3:0]  ptr;
  reg  [31:0] to_cnt;
  reg  [7:0]  regs [0:15];
  reg         pwr_done = 1'b0;                                     // marks the first reset as power-up
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire        fifo_in_ready;
  wire        wr_valid;
  wire [11:0] wr_word;
  reg         push_byte;
  reg  [11:0] push_word;
  integer     i;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  // two stages before anything reads the pins
  always @(posedge clk_sys) begin
    if (rst) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  assign scl_rise  = scl_sync[1] && !scl_q;
  assign scl_fall  = !scl_sync[1] && scl_q;
  assign start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
  assign stop_det  = scl_sync[1] && scl_q && !sda_q && sda_sync[1];

  // ---------------------------------------------------------------
  // bus timeout
  // ---------------------------------------------------------------
  // counts from a start out of idle, survives repeated start
  always @(posedge clk_sys) begin
    if (rst || stop_det || state == ST_IDLE) begin
      to_cnt    <= 32'h0000_0000;
    end else if (state != ST_DEAD) begin
      to_cnt <= to_cnt + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    push_byte <= 1'b0;
    if (rst) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      is_read    <= 1'b0;
      first_byte <= 1'b0;
      ptr        <= 4'h0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      bus_active <= 1'b0;
      timed_out  <= 1'b0;
      push_word  <= 12'h000;
    end else if (start_det) begin
      // a fresh start re-arms; after a timeout with no stop, to_cnt still trips it again next cycle
      state      <= ST_ADDR;
      bit_cnt    <= 4'h0;
      sda_oe     <= 1'b0;
      bus_active <= 1'b1;
      timed_out  <= 1'b0;
    end else if (stop_det) begin
      state      <= ST_IDLE;
      sda_oe     <= 1'b0;
      bus_active <= 1'b0;
    end else if (state != ST_IDLE && state != ST_DEAD &&
                 to_cnt >= TIMEOUT_CYC - 1) begin
      state     <= ST_DEAD;
      sda_oe    <= 1'b0;
      timed_out <= 1'b1;
    end else begin
      case (state)
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (state == ST_ADDR) begin
              if (shift[7:1] == `RTCIS_SLAVE_ADDR) begin
                is_read    <= shift[0];
                first_byte <= 1'b1;
                sda_oe     <= 1'b1;
                state      <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              sda_oe <= 1'b1;
              state  <= ST_ACK;
              if (first_byte) begin
                ptr        <= shift[3:0];
                first_byte <= 1'b0;
              end else begin
                push_byte <= 1'b1;
                push_word <= {ptr, shift};
                ptr       <= ptr + 4'h1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (is_read) begin
              first_byte <= 1'b0;
              sda_oe     <= ~regs[ptr][7];
              shift      <= {regs[ptr][6:0], 1'b1};
              ptr        <= ptr + 4'h1;
              bit_cnt    <= 4'h1;
              state      <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state  <= ST_RACK;
            end else begin
              sda_oe  <= ~shift[7];
              shift   <= {shift[6:0], 1'b1};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_sync[1]) begin
              state <= ST_DEAD;
            end else begin
              state <= ST_ACK;
            end
          end
        end
        ST_DEAD: begin
          sda_oe <= 1'b0;
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write path through the fifo
  // ---------------------------------------------------------------
  // fifo never fills at i2c pace; fifo_in_ready is unused, a push when full is dropped
  rtcis_fifo #(
    .WIDTH (12),
    .DEPTH (4),
    .AW    (2)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (1'b0),
    .in_valid  (push_byte),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (wr_valid),
    .out_ready (1'b1),
    .out_data  (wr_word)
  );

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // ram and event flags keep no reset beyond power-up
  always @(posedge clk_sys) begin
    if (rst && !pwr_done) begin
      for (i = 0; i < 16; i = i + 1) begin
        regs[i] <= `RTCIS_RST_OTHER;
      end
      regs[`RTCIS_REG_FLAG] <= `RTCIS_RST_FLAG;
      regs[`RTCIS_REG_EXT]  <= `RTCIS_RST_EXT;
      pwr_done <= 1'b1;
    end else if (wr_valid && !timed_out) begin
      if (wr_word[11:8] == `RTCIS_REG_FLAG) begin
        // flags only clear; a one leaves them alone
        regs[`RTCIS_REG_FLAG] <= (regs[`RTCIS_REG_FLAG] & (wr_word[7:0] | ~`RTCIS_FLAG_W0_MASK))
                               | (wr_word[7:0] & ~`RTCIS_FLAG_W0_MASK);
      end else begin
        regs[wr_word[11:8]] <= wr_word[7:0];
      end
    end
  end

  // mirror of key registers
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
      flag_reg <= `RTCIS_RST_FLAG;
    end else begin
      ctrl_reg <= regs[`RTCIS_REG_CTRL];
      flag_reg <= regs[`RTCIS_REG_FLAG];
    end
  end
endmodule // rtcis_slave
`default_nettype wire

// >>> testbench/rtcis_slave_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------
// pin-level checks on the i2c slave port
// ---------------------------------------------------------
module rtcis_slave_checker #(
  parameter int TIMEOUT_CYC = 2000
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // i2c pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // register view
  input wire logic [7:0] ctrl_reg,
  input wire logic [7:0] flag_reg,
  input wire logic       bus_active,
  input wire logic       timed_out
);
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  logic [31:0] act_cnt;
  // own line sampler, edges judged at the same stage as the design's own sampler
  always @(posedge clk_sys) begin
    scl_q <= {scl_q[1:0], scl_in};
    sda_q <= {sda_q[1:0], sda_in};
    if (rst || !bus_active) begin
      act_cnt <= 32'h0000_0000;
    end else if (!timed_out) begin
      act_cnt <= act_cnt + 32'h0000_0001;
    end
  end
  wire start_ev = scl_q[2] && scl_q[1] && sda_q[2] && !sda_q[1];
  wire stop_ev  = scl_q[2] && scl_q[1] && !sda_q[2] && sda_q[1];
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  idle_quiet_a: assert property (!bus_active && !$past(bus_active) |-> !sda_oe)
    else $error("sda driven while idle");
  start_seen_a: assert property (start_ev |-> ##[0:6] bus_active)
    else $error("start missed");
  stop_seen_a: assert property (stop_ev |-> ##[0:6] !bus_active)
    else $error("stop missed");
  timeout_clear_a: assert property (start_ev |-> ##[0:6] !timed_out)
    else $error("start left timeout set");
  timeout_quiet_a: assert property (timed_out |-> !sda_oe)
    else $error("sda driven after timeout");
  timeout_late_a: assert property (act_cnt <= TIMEOUT_CYC + 8)
    else $error("timeout too late");
  timeout_early_a: assert property ($rose(timed_out) |-> $past(act_cnt) >= TIMEOUT_CYC - 8)
    else $error("timeout too early");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_q[1])
    else $error("sda changed with scl high");
  flag_w0_a: assert property (((flag_reg & ~$past(flag_reg)) & 8'h3b) == 8'h00)
    else $error("event flag set");
  cover property ($rose(timed_out));
  cover property (start_ev && bus_active);
  cover property ($rose(sda_oe));
endmodule // rtcis_slave_checker
bind rtcis_slave rtcis_slave_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .ctrl_reg(ctrl_reg), .flag_reg(flag_reg), .bus_active(bus_active), .timed_out(timed_out));
`default_nettype wire

// >>> testbench/rtcis_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------
// i2c master, quarter bit of two system clocks
// ---------------------------------------------------------
module rtcis_master_model (
  // reference and sensed line
  input  wire logic clk_sys,
  input  wire logic sda,
  // pins: scl push-pull, sda open drain
  output var  logic scl,
  output var  logic sda_low
);
  // idle bus: both high, clock stands still
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge clk_sys);
  endtask
  // sda falls under high scl, also used as restart
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  // sda rises under high scl, then the clock stays high
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  // data moves only while scl is low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // msb first, ninth bit is the acknowledge either way
  task automatic xb(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic sack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(mack, sack);
  endtask
endmodule // rtcis_master_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------
// self-checking bench for the i2c port
// ---------------------------------------------------------
module testbench;
  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  wire        scl;
  wire        sda_low;
  wire        sda_oe;
  wire        sda_out;
  wire        bus_active;
  wire        timed_out;
  wire  [7:0] ctrl_reg;
  wire  [7:0] flag_reg;
  logic [7:0] d, v, c, f, r;
  logic       a;
  int         miscompares = 0, total_checks = 0, cycles = 0, i;
  // open-drain line with pull-up
  wire        sda = !(sda_low || (sda_oe && !sda_out));
  always #12.5 clk_sys = ~clk_sys;
  rtcis_master_model m_u (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
  rtcis_slave #(.TIMEOUT_CYC(2000)) dut_u (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .ctrl_reg(ctrl_reg), .flag_reg(flag_reg),
    .bus_active(bus_active), .timed_out(timed_out));
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic nak);
    m_u.xb(b, 1'b1, r, a);
    chk(a === nak, "acknowledge");
  endtask
  task automatic recv(input logic nak, input logic [7:0] e);
    m_u.xb(8'hff, nak, r, a);
    chk(r === e, "read data");
  endtask
  // one write of a pointer and one byte, then let the copy land
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] b);
    m_u.start();
    send(8'h64, 1'b0);
    send(p, 1'b0);
    send(b, 1'b0);
    m_u.stop();
    repeat (4) @(negedge clk_sys);
  endtask
  function automatic logic [7:0] w0(input logic [7:0] o, input logic [7:0] w);
    return o & w & 8'h3b;
  endfunction
  // hang guard, well above the expected run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk(flag_reg === 8'h02, "power-up flags");
    chk(sda_out === 1'b0, "open drain level");
    i = $urandom(91929);
    // top register, wrap into 0, read back across a restart
    for (i = 0; i < 3; i++) begin
      c = $urandom & 8'hf8;
      v = $urandom & 8'h7f;
      wr_reg(8'h0f, c);
      chk(ctrl_reg === c, "control copy");
      m_u.start();
      send(8'h64, 1'b0);
      send(8'h0f, 1'b0);
      send(c, 1'b0);
      send(v, 1'b0);
      m_u.start();
      send(8'h64, 1'b0);
      send(8'h0f, 1'b0);
      m_u.start();
      send(8'h65, 1'b0);
      recv(1'b0, c);
      recv(1'b1, v);
      m_u.stop();
    end
    // event flags only clear
    f = 8'h02;
    for (i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h3b : ((i == 1) ? ($urandom & 8'h3b) : 8'h00);
      wr_reg(8'h0e, d);
      f = w0(f, d);
      chk(flag_reg === f, "flag write");
    end
    // foreign addresses, neighbour first
    for (i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'h66 : $urandom;
      d = (d[7:1] == 7'h32) ? 8'h00 : d;
      m_u.start();
      send(d, 1'b1);
      m_u.stop();
    end
    // stop three bits into a data byte
    m_u.start();
    send(8'h64, 1'b0);
    send(8'h0f, 1'b0);
    for (i = 0; i < 3; i++) begin
      m_u.bit_io(1'b1, a);
    end
    m_u.stop();
    repeat (8) @(negedge clk_sys);
    chk(bus_active === 1'b0 && ctrl_reg === c, "abort");
    // transaction held past the limit
    m_u.start();
    send(8'h64, 1'b0);
    send(8'h0f, 1'b0);
    repeat (2100) @(negedge clk_sys);
    chk(timed_out === 1'b1, "timeout");
    send(c ^ 8'hf8, 1'b1);
    recv(1'b1, 8'hff);
    m_u.stop();
    repeat (4) @(negedge clk_sys);
    chk(ctrl_reg === c, "write after timeout");
    m_u.start();
    send(8'h64, 1'b0);
    m_u.stop();
    conclude();
  end
endmodule // testbench
`default_nettype wire
